/* tb_top.sv */
// self-checking bench for the type-c attach detect block
`timescale 1ns/1ns
module tb_top;
  localparam tcad_pkg::tcad_term_t OP = tcad_pkg::TERM_OPEN;
  localparam tcad_pkg::tcad_term_t RD = tcad_pkg::TERM_RD;
  localparam tcad_pkg::tcad_term_t RA = tcad_pkg::TERM_RA;
  logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, role_dfp = 1'b1;
  logic vbus_present = 1'b0, fw_use_trimmed = 1'b0;
  logic straps_grounded = 1'b0, sw_reverse = 1'b0;
  logic [1:0] adv_level = 2'h0, snk_level_a = 2'h0, snk_level_b = 2'h0;
  logic [11:0] five_volt_current_limit = 12'hFFF;
  logic [11:0] sw_current_adc = 12'h000;
  tcad_pkg::tcad_term_t term_a = OP, term_b = OP;
  logic below_attach_a, below_attach_b, below_cable_a, below_cable_b;
  logic pullup_en_a, pullup_en_b, trimmed_pulldown_en, watch_a, watch_b;
  logic dead_battery_pulldown_en, bus_power_en, cable_power_a, attached;
  logic cable_power_b, orient_b, attach_event, sw_limit, sw_off_reverse;
  logic [1:0] pullup_level, snk_adv;
  logic [3:0] conn_state;
  logic [11:0] five_volt_current;
  int miscompares = 0;
  int comparisons = 0;
  tcad_partner i_partner (.*);
  tcad_detect i_dut (.*);
  always #5 core_clk = ~core_clk;
  // inputs move 1 ns after the edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic cmp(input logic [11:0] g, input logic [11:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic do_reset;
    rst_b = 1'b0;
    tick(20);
    rst_b = 1'b1;
  endtask : do_reset
  // one edge captures the pair, debounce is 10000 edges, then state and outputs move together on the next edge
  task automatic t_pair(input tcad_pkg::tcad_term_t a, b,
      input logic [3:0] s, input logic [4:0] o, input logic ob, ev);
    do_reset();
    adv_level = (adv_level == 2'h2) ? 2'h0 : adv_level + 2'h1;
    term_a = a;
    term_b = b;
    // the decode edge is the 10002nd after the pair is applied
    tick(10002);
    cmp({11'h000, attach_event}, {11'h000, ev});
    tick(3);
    cmp({8'h00, conn_state}, {8'h00, s});
    cmp({7'h00, bus_power_en, cable_power_a, cable_power_b, watch_a,
        watch_b}, {7'h00, o});
    cmp({11'h000, orient_b}, {11'h000, ob});
    cmp({10'h000, pullup_en_a, pullup_en_b}, {10'h000, o[1:0]});
    cmp({10'h000, pullup_level}, {10'h000, adv_level});
    cmp({11'h000, attach_event}, 12'h000);
    $display("pair test done");
  endtask : t_pair
  task automatic t_sink;
    do_reset();
    role_dfp = 1'b0;
    snk_level_a = 2'h2;
    snk_level_b = 2'h1;
    tick(3);
    cmp({11'h000, attached}, 12'h000);
    cmp({11'h000, dead_battery_pulldown_en}, 12'h001);
    vbus_present = 1'b1;
    tick(3);
    cmp({11'h000, attached}, 12'h001);
    cmp({10'h000, snk_adv}, 12'h002);
    fw_use_trimmed = 1'b1;
    tick(3);
    cmp({11'h000, trimmed_pulldown_en}, 12'h001);
    straps_grounded = 1'b1;
    tick(2);
    cmp({11'h000, dead_battery_pulldown_en}, 12'h000);
    role_dfp = 1'b1;
    $display("sink test done");
  endtask : t_sink
  // equal current is not an overcurrent, one above is
  task automatic t_limit;
    do_reset();
    five_volt_current_limit = 12'h400;
    sw_current_adc = 12'h400;
    tick(4);
    cmp({11'h000, sw_limit}, 12'h000);
    cmp(five_volt_current, 12'h400);
    sw_current_adc = 12'h401;
    sw_reverse = 1'b1;
    tick(4);
    cmp({11'h000, sw_limit}, 12'h001);
    cmp({11'h000, sw_off_reverse}, 12'h001);
    $display("limit test done");
  endtask : t_limit
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    t_pair(OP, OP, tcad_pkg::ST_IDLE, 5'b00011, 1'b0, 1'b0);
    t_pair(RD, OP, tcad_pkg::ST_UFP_A, 5'b10010, 1'b0, 1'b1);
    t_pair(OP, RD, tcad_pkg::ST_UFP_B, 5'b10001, 1'b1, 1'b1);
    t_pair(RA, OP, tcad_pkg::ST_CBL_A, 5'b00011, 1'b0, 1'b0);
    t_pair(OP, RA, tcad_pkg::ST_CBL_B, 5'b00011, 1'b0, 1'b0);
    t_pair(RA, RD, tcad_pkg::ST_CBL_UFP_A, 5'b11001, 1'b1, 1'b1);
    t_pair(RD, RA, tcad_pkg::ST_CBL_UFP_B, 5'b10110, 1'b0, 1'b1);
    t_pair(RD, RD, tcad_pkg::ST_DEBUG, 5'b00011, 1'b0, 1'b1);
    t_pair(RA, RA, tcad_pkg::ST_AUDIO, 5'b00011, 1'b0, 1'b1);
    t_sink();
    t_limit();
    print_verdict();
  end
  // the tests need about 90300 cycles
  initial begin
    #1000000;
    miscompares++;
    print_verdict();
  end
endmodule : tb_top

/* tcad_detect.sv */
// attach, orientation and 5 V switch control for a type-c port
`timescale 1ns/1ns
`include "tcad_map.svh"
//////////////////////////////////////////////////////////////////////
// overview
// each configuration line feeds two comparators: below the attach
// threshold means some pulldown is present, below the active-cable
// threshold means the deeper Ra pulldown. the pair of terminations is
// debounced as a whole and then decoded into one connection state.
// as a source the state picks bus power, cable power and which lines
// stay watched. the pullups follow the watched lines, so a line that
// no longer matters is not loaded.
// as a sink the state follows bus voltage only; the line levels are
// used just to decode the current offered by the far end.
// the 5 V switch limit compares the converter reading with the limit
// input every cycle; the real clamp is analogue, this flag only tells
// firmware that limiting is active.
// limitation: the debounce length is a fixed macro, so a slower core
// clock needs the header changed to keep the same settle time.
//////////////////////////////////////////////////////////////////////
module tcad_detect (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // role and advertised level
  input wire logic role_dfp,
  input wire logic [1:0] adv_level,
  // line comparators
  input wire logic below_attach_a,
  input wire logic below_attach_b,
  input wire logic below_cable_a,
  input wire logic below_cable_b,
  input wire logic [1:0] snk_level_a,
  input wire logic [1:0] snk_level_b,
  // sink side and pulldown control
  input wire logic vbus_present,
  input wire logic fw_use_trimmed,
  input wire logic straps_grounded,
  // 5 V switch sense
  input wire logic [11:0] five_volt_current_limit,
  input wire logic [11:0] sw_current_adc,
  input wire logic sw_reverse,
  // line terminations presented
  output logic [1:0] pullup_level,
  output logic pullup_en_a,
  output logic pullup_en_b,
  output logic trimmed_pulldown_en,
  output logic dead_battery_pulldown_en,
  // power and connection status
  output logic bus_power_en,
  output logic cable_power_a,
  output logic cable_power_b,
  output logic watch_a,
  output logic watch_b,
  output logic attached,
  output logic orient_b,
  output logic [3:0] conn_state,
  output logic [1:0] snk_adv,
  // firmware event and switch status
  output logic attach_event,
  output logic sw_limit,
  output logic sw_off_reverse,
  output logic [11:0] five_volt_current
);
  localparam int unsigned DEB = `TCAD_DEBOUNCE_CYC;
  tcad_pkg::tcad_regs_t r_q, r_d;
  tcad_pkg::tcad_term_t ta, tb;
  logic was_att;

  //////////////////////////////////////////////////////////////////////
  // termination decode per line
  // RL11 cable threshold means Ra
  always_comb begin
    // Ra pulls lower than Rd, so check the deeper threshold first
    ta = below_cable_a ? tcad_pkg::TERM_RA :
         below_attach_a ? tcad_pkg::TERM_RD : tcad_pkg::TERM_OPEN;
    tb = below_cable_b ? tcad_pkg::TERM_RA :
         below_attach_b ? tcad_pkg::TERM_RD : tcad_pkg::TERM_OPEN;
  end

  //////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    r_d = r_q;
    r_d.event_p = 1'b0;
    was_att = r_q.attached;
    r_d.term_a = ta;
    r_d.term_b = tb;
    // debounce: pair must hold steady before the state follows it
    if (ta != r_q.term_a || tb != r_q.term_b) begin
      r_d.deb_cnt = 17'h00000;
    end else if (r_q.deb_cnt < 17'(DEB)) begin
      r_d.deb_cnt = r_q.deb_cnt + 17'h00001;
    end
    if (!role_dfp) begin
      // RL13 sink waits for pullup
      // RL14 bus voltage marks attach
      r_d.state = vbus_present ? tcad_pkg::ST_SNK_ATT :
                  tcad_pkg::ST_SNK_WAIT;
      // RL15 decode offered current
      r_d.snk_adv = (snk_level_a > snk_level_b) ? snk_level_a : snk_level_b;
    end else if (r_q.deb_cnt == 17'(DEB)) begin
      // RL21 pair decoded to one state
      unique case ({r_q.term_a, r_q.term_b})
        // RL1 nothing attached
        {tcad_pkg::TERM_OPEN, tcad_pkg::TERM_OPEN}:
          r_d.state = tcad_pkg::ST_IDLE;
        // RL2 sink on line a
        {tcad_pkg::TERM_RD, tcad_pkg::TERM_OPEN}:
          r_d.state = tcad_pkg::ST_UFP_A;
        // RL3 sink on line b
        {tcad_pkg::TERM_OPEN, tcad_pkg::TERM_RD}:
          r_d.state = tcad_pkg::ST_UFP_B;
        // RL4 cable on line a
        {tcad_pkg::TERM_RA, tcad_pkg::TERM_OPEN}:
          r_d.state = tcad_pkg::ST_CBL_A;
        // RL5 cable on line b
        {tcad_pkg::TERM_OPEN, tcad_pkg::TERM_RA}:
          r_d.state = tcad_pkg::ST_CBL_B;
        // RL6 cable a, sink b
        {tcad_pkg::TERM_RA, tcad_pkg::TERM_RD}:
          r_d.state = tcad_pkg::ST_CBL_UFP_A;
        // RL7 cable b, sink a
        {tcad_pkg::TERM_RD, tcad_pkg::TERM_RA}:
          r_d.state = tcad_pkg::ST_CBL_UFP_B;
        // RL8 accessory classes
        {tcad_pkg::TERM_RD, tcad_pkg::TERM_RD}:
          r_d.state = tcad_pkg::ST_DEBUG;
        {tcad_pkg::TERM_RA, tcad_pkg::TERM_RA}:
          r_d.state = tcad_pkg::ST_AUDIO;
        default: r_d.state = tcad_pkg::ST_IDLE;
      endcase
      // RL12 watched line opening means detach
      if (r_q.attached && r_q.watch_a && !r_q.watch_b &&
          r_q.term_a == tcad_pkg::TERM_OPEN) begin
        r_d.state = tcad_pkg::ST_IDLE;
      end
      if (r_q.attached && r_q.watch_b && !r_q.watch_a &&
          r_q.term_b == tcad_pkg::TERM_OPEN) begin
        r_d.state = tcad_pkg::ST_IDLE;
      end
      // RL8 either line open ends accessory
      if ((r_q.state == tcad_pkg::ST_DEBUG ||
           r_q.state == tcad_pkg::ST_AUDIO) &&
          (r_q.term_a == tcad_pkg::TERM_OPEN ||
           r_q.term_b == tcad_pkg::TERM_OPEN)) begin
        r_d.state = tcad_pkg::ST_IDLE;
      end
    end else if (r_q.state inside {tcad_pkg::ST_SNK_WAIT,
                                   tcad_pkg::ST_SNK_ATT}) begin
      r_d.state = tcad_pkg::ST_IDLE;
    end
    // outputs decoded from next state; every state lists all six so a
    // new state cannot quietly inherit power from the defaults
    r_d.bus_pwr = 1'b0;
    r_d.cable_pwr_a = 1'b0;
    r_d.cable_pwr_b = 1'b0;
    r_d.watch_a = 1'b1;
    r_d.watch_b = 1'b1;
    r_d.attached = 1'b0;
    unique case (r_d.state)
      // RL1 both watched, no power
      tcad_pkg::ST_IDLE: begin
        r_d.bus_pwr = 1'b0;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b0;
      end
      // RL2 watch a
      tcad_pkg::ST_UFP_A: begin
        r_d.bus_pwr = 1'b1;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b0;
        r_d.attached = 1'b1;
      end
      // RL3 watch b
      tcad_pkg::ST_UFP_B: begin
        r_d.bus_pwr = 1'b1;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b0;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b1;
      end
      // RL4 both watched, no power yet
      tcad_pkg::ST_CBL_A: begin
        r_d.bus_pwr = 1'b0;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b0;
      end
      // RL5 both watched, no power yet
      tcad_pkg::ST_CBL_B: begin
        r_d.bus_pwr = 1'b0;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b0;
      end
      // RL6 power cable on a, watch b
      tcad_pkg::ST_CBL_UFP_A: begin
        r_d.bus_pwr = 1'b1;
        r_d.cable_pwr_a = 1'b1;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b0;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b1;
      end
      // RL7 power cable on b, watch a
      tcad_pkg::ST_CBL_UFP_B: begin
        r_d.bus_pwr = 1'b1;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b1;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b0;
        r_d.attached = 1'b1;
      end
      // RL8 accessories: no power, both lines watched for detach
      tcad_pkg::ST_DEBUG, tcad_pkg::ST_AUDIO: begin
        r_d.bus_pwr = 1'b0;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b1;
      end
      // RL13 sink waiting for a source
      tcad_pkg::ST_SNK_WAIT: begin
        r_d.bus_pwr = 1'b0;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b0;
      end
      // RL14 sink attached by bus voltage
      tcad_pkg::ST_SNK_ATT: begin
        r_d.bus_pwr = 1'b0;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b1;
      end
      // unused codes fall back to a safe, unpowered idle
      default: begin
        r_d.bus_pwr = 1'b0;
        r_d.cable_pwr_a = 1'b0;
        r_d.cable_pwr_b = 1'b0;
        r_d.watch_a = 1'b1;
        r_d.watch_b = 1'b1;
        r_d.attached = 1'b0;
      end
    endcase
    // RL21 event on attach change
    if (r_d.attached != was_att) begin
      r_d.event_p = 1'b1;
    end
    // RL16 dead-battery pulldown until firmware trims
    if (fw_use_trimmed) begin
      r_d.trimmed = 1'b1;
    end
    // RL18 limit whenever current exceeds
    r_d.limiting = sw_current_adc > five_volt_current_limit;
    // RL19 reading registered for firmware
    r_d.isense = sw_current_adc;
  end

  //////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
      r_q.watch_a <= 1'b1;
      r_q.watch_b <= 1'b1;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin-facing outputs
  // RL9 RL10 pullup at advertised level
  assign pullup_level = adv_level;
  assign pullup_en_a = role_dfp && r_q.watch_a;
  assign pullup_en_b = role_dfp && r_q.watch_b;
  // RL17 grounded straps leave lines floating
  assign trimmed_pulldown_en = !role_dfp && r_q.trimmed && !straps_grounded;
  assign dead_battery_pulldown_en = !role_dfp && !r_q.trimmed &&
                                    !straps_grounded;
  assign bus_power_en = r_q.bus_pwr && role_dfp;
  assign cable_power_a = r_q.cable_pwr_a;
  assign cable_power_b = r_q.cable_pwr_b;
  assign watch_a = r_q.watch_a;
  assign watch_b = r_q.watch_b;
  assign attached = r_q.attached;
  assign orient_b = r_q.state == tcad_pkg::ST_UFP_B ||
                    r_q.state == tcad_pkg::ST_CBL_UFP_A;
  assign conn_state = r_q.state;
  assign snk_adv = r_q.snk_adv;
  assign attach_event = r_q.event_p && clk_en;
  assign sw_limit = r_q.limiting;
  // RL20 reverse flow opens the switch
  assign sw_off_reverse = sw_reverse;
  assign five_volt_current = r_q.isense;
endmodule : tcad_detect

/* tcad_detect_assertions.sv */
// port checker for the type-c attach detect block
`timescale 1ns/1ns
module tcad_detect_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic role_dfp,
  input wire logic [1:0] adv_level,
  input wire logic straps_grounded,
  input wire logic [11:0] five_volt_current_limit,
  input wire logic [11:0] sw_current_adc,
  input wire logic [1:0] pullup_level,
  input wire logic pullup_en_a,
  input wire logic watch_a,
  input wire logic trimmed_pulldown_en,
  input wire logic dead_battery_pulldown_en,
  input wire logic bus_power_en,
  input wire logic cable_power_a,
  input wire logic cable_power_b,
  input wire logic attach_event,
  input wire logic sw_limit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // level-style checks tie outputs straight to their causes
  property p_lvl; pullup_level == adv_level; endproperty
  a_lvl: assert property (p_lvl) else $error("pullup level");
  property p_pen; pullup_en_a == (role_dfp && watch_a); endproperty
  a_pen: assert property (p_pen) else $error("pullup enable");
  property p_evt; attach_event |=> !attach_event; endproperty
  a_evt: assert property (p_evt) else $error("event width");
  property p_cab; !(cable_power_a && cable_power_b); endproperty
  a_cab: assert property (p_cab) else $error("cable power both");
  // a sink never sources the bus nor drives the pullup
  property p_snk; !role_dfp |-> !bus_power_en && !pullup_en_a; endproperty
  a_snk: assert property (p_snk) else $error("sink sources");
  property p_pd; !(trimmed_pulldown_en && dead_battery_pulldown_en);
  endproperty
  a_pd: assert property (p_pd) else $error("two pulldowns");
  property p_strap; straps_grounded |-> !dead_battery_pulldown_en;
  endproperty
  a_strap: assert property (p_strap) else $error("strap pulldown");
  // three sampled overcurrent edges leave time for the register
  property p_lim;
    (clk_en && sw_current_adc > five_volt_current_limit) [*3] |-> sw_limit;
  endproperty
  a_lim: assert property (p_lim) else $error("no limit");
  c_evt: cover property (attach_event);
  c_cab: cover property (cable_power_a);
  c_lim: cover property (sw_limit);
endmodule : tcad_detect_assertions
bind tcad_detect tcad_detect_assertions i_chk (.*);

/* tcad_map.svh */
// constants for the type-c attach and orientation detect block
// Function
// RL1: DFP open/open: watch both, power off
// RL2: DFP Rd/open: bus power, watch line a
// RL3: DFP open/Rd: bus power, watch line b
// RL4: DFP Ra/open: watch b attach, a detach
// RL5: DFP open/Ra: watch a attach, b detach
// RL6: DFP Ra/Rd: bus and cable power a
// RL7: DFP Rd/Ra: bus and cable power b
// RL8: Rd/Rd debug, Ra/Ra audio, either detaches
// RL9: DFP drives pullup, attach below threshold
// RL10: advertise default, 1.5 A or 3 A
// RL11: below active-cable threshold means Ra
// RL12: disconnect when watched line rises above
// RL13: UFP presents trimmed pulldown, waits pullup
// RL14: UFP attach taken from bus voltage
// RL15: UFP decodes offered current from pullup
// RL16: dead-battery pulldown until switched to trimmed
// RL17: grounded straps give high impedance lines
// RL18: automatic 5 V switch current limit
// RL19: 5 V switch current reading made available
// RL20: 5 V switch sources only, reverse limited
// RL21: decode state, event on attach change
`ifndef TCAD_MAP_SVH
`define TCAD_MAP_SVH
`define TCAD_ADV_DEFAULT 2'h0
`define TCAD_ADV_1P5 2'h1
`define TCAD_ADV_3P0 2'h2
`define TCAD_ILIM_RST 12'hFFF
`define TCAD_DEBOUNCE_NS 100000
`define TCAD_CLK_NS 10
`define TCAD_DEBOUNCE_CYC (`TCAD_DEBOUNCE_NS / `TCAD_CLK_NS)
`endif

/* tcad_partner.sv */
// behavioural type-c partner turning terminations into comparator levels
`timescale 1ns/1ns
module tcad_partner (
  input tcad_pkg::tcad_term_t term_a,
  input tcad_pkg::tcad_term_t term_b,
  output logic below_attach_a,
  output logic below_attach_b,
  output logic below_cable_a,
  output logic below_cable_b
);
  // rd or ra pulls the line under the attach threshold
  assign below_attach_a = (term_a != tcad_pkg::TERM_OPEN);
  assign below_attach_b = (term_b != tcad_pkg::TERM_OPEN);
  // only ra drops under the active-cable threshold
  assign below_cable_a = (term_a == tcad_pkg::TERM_RA);
  assign below_cable_b = (term_b == tcad_pkg::TERM_RA);
endmodule : tcad_partner

/* tcad_pkg.sv */
// types for the type-c attach and orientation detect block
package tcad_pkg;
  // termination seen on one line
  typedef enum logic [1:0] {TERM_OPEN, TERM_RD, TERM_RA} tcad_term_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_UFP_A, ST_UFP_B, ST_CBL_A, ST_CBL_B, ST_CBL_UFP_A,
    ST_CBL_UFP_B, ST_DEBUG, ST_AUDIO, ST_SNK_WAIT, ST_SNK_ATT
  } tcad_state_t;
  typedef struct packed {
    tcad_state_t state;
    tcad_term_t term_a;
    tcad_term_t term_b;
    logic [16:0] deb_cnt;
    logic bus_pwr;
    logic cable_pwr_a;
    logic cable_pwr_b;
    logic watch_a;
    logic watch_b;
    logic attached;
    logic event_p;
    logic [1:0] snk_adv;
    logic trimmed;
    logic limiting;
    logic [11:0] isense;
  } tcad_regs_t;
endpackage : tcad_pkg
